// ---- design/cpg_regs.svh ----
// Constants for the complementary PWM generator
`ifndef CPG_REGS_SVH
`define CPG_REGS_SVH

// Oscillator period in ns, and the PWM clock period at prescale code 000
`define CPG_OSC_PERIOD_NS    40
`define CPG_PWM_CLK_BASE_NS  `CPG_OSC_PERIOD_NS

// Largest legal prescale code (110); each step doubles the PWM clock period
`define CPG_PRESCALE_MAX     3'h6
`define CPG_PRESCALE_WIDTH   3
`define CPG_DIV_WIDTH        6

// Width of the limit source select field, and the number of comparators
`define CPG_LIMIT_SEL_WIDTH  5
`define CPG_LIMIT_SOURCES    32

// Override data codes: bit 1 drives the high side, bit 0 the low side
`define CPG_OVR_HIGH_BIT     1
`define CPG_OVR_LOW_BIT      0
`define CPG_OVR_ZERO_DUTY    2'h1
`define CPG_OVR_FULL_DUTY    2'h2

// Centre-aligned compare leads the count by one
`define CPG_CENTER_LEAD      1

`endif

// ---- design/cpg_pkg.sv ----
// Types shared by the complementary PWM generator
package cpg_pkg;
    typedef enum logic {
        CPG_COUNT_UP   = 1'b0,
        CPG_COUNT_DOWN = 1'b1
    } cpg_dir_e;
endpackage : cpg_pkg

// ---- design/cpg_prescaler.sv ----
// PWM clock prescaler: one tick every 2^code oscillator periods
`timescale 1ns/1ps
`include "cpg_regs.svh"

module cpg_prescaler (
    input  wire logic [`CPG_PRESCALE_WIDTH-1:0] prescale,
    input  wire logic                           mclk,
    input  wire logic                           rst_b,
    input  wire logic                           run,
    output logic                                tick
);
    logic [`CPG_DIV_WIDTH-1:0]      div;
    logic [`CPG_DIV_WIDTH-1:0]      next_div;
    logic [`CPG_DIV_WIDTH-1:0]      mask;
    logic [`CPG_PRESCALE_WIDTH-1:0] code;

    always_comb begin
        // Code 111 is not a legal rate; clamp it to the slowest one
        code     = (prescale > `CPG_PRESCALE_MAX) ? `CPG_PRESCALE_MAX : prescale;
        mask     = (`CPG_DIV_WIDTH'(1) << code) - `CPG_DIV_WIDTH'(1);
        tick     = run && (div == mask);
        next_div = (tick || !run) ? '0 : div + `CPG_DIV_WIDTH'(1);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div <= '0;
        end else begin
            div <= next_div;
        end
    end

    chk_prescale_rate: assert property (@(posedge mclk) disable iff (!rst_b)
        run && $past(run) && prescale == 3'h0 |-> tick)
        else $error("prescale 000 must tick every oscillator period");
endmodule : cpg_prescaler

// ---- design/cpg_dead_time.sv ----
// Dead-time insertion and interlock for the output pair
`timescale 1ns/1ps

module cpg_dead_time #(
    parameter int WIDTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic             reqHigh,
    input  wire logic             reqLow,
    input  wire logic [WIDTH-1:0] dtHigh,
    input  wire logic [WIDTH-1:0] dtLow,
    output logic                  outHigh,
    output logic                  outLow
);
    logic [1:0]       req;
    logic [1:0]       out;
    logic [1:0]       next_out;
    logic [WIDTH-1:0] dt [2];
    logic [WIDTH-1:0] cnt [2];
    logic [WIDTH-1:0] next_cnt [2];

    assign req     = {reqLow, reqHigh};
    assign dt[0]   = dtHigh;
    assign dt[1]   = dtLow;
    assign outHigh = out[0];
    assign outLow  = out[1];

    // Every turn-on waits for the partner to be off plus its dead time,
    // whatever caused the edge, so late duty writes cannot shorten it
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            next_out[i] = out[i];
            next_cnt[i] = cnt[i];
            if (!run || !req[i]) begin
                next_out[i] = 1'b0;
                next_cnt[i] = '0;
            end else if (!out[i] && !out[1-i] && !(i == 1 && req[0])) begin
                if (cnt[i] >= dt[i]) begin
                    next_out[i] = 1'b1;
                end else if (tick) begin
                    next_cnt[i] = cnt[i] + WIDTH'(1);
                end
            end else if (!out[i]) begin
                next_cnt[i] = '0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            out    <= 2'h0;
            cnt[0] <= '0;
            cnt[1] <= '0;
        end else begin
            out    <= next_out;
            cnt[0] <= next_cnt[0];
            cnt[1] <= next_cnt[1];
        end
    end

    chk_no_overlap: assert property (@(posedge mclk) disable iff (!rst_b)
        !(outHigh && outLow))
        else $error("both outputs on at once");

    chk_dead_gap: assert property (@(posedge mclk) disable iff (!rst_b)
        $rose(outHigh) && dtHigh != '0 |-> $past(!outLow, 2))
        else $error("high side turned on without dead time");
endmodule : cpg_dead_time

// ---- design/cpg_generator.sv ----
// Complementary PWM generator with dead time, overrides and current reset
//
// What this block does
// - Immediate update changes outputs at once
// - Independent or master time base, same dead time
// - Duty zero holds low; duty=period holds high
// - Centre mode: period+2 full, zero empty
// - Edge mode: period+1 full, zero empty
// - Override data 01 empty, 10 full
// - Override sync: period boundary or next clock
// - Separate high and low override enables
// - Current-reset mode restarts cycle every event
// - Five-bit select picks the limit comparator
// - Prescale codes 000-110 double PWM clock
// - Code 000 gives one oscillator period
// - Buffered updates load at period boundary; enable
// - Duty source: own or shared master duty
`timescale 1ns/1ps
`include "cpg_regs.svh"

module cpg_generator #(
    parameter int WIDTH         = 16,
    parameter int LIMIT_SOURCES = `CPG_LIMIT_SOURCES
) (
    input  wire logic                            mclk,
    input  wire logic                            rst_b,
    input  wire logic                            timeBaseEnable,
    input  wire logic                            independentTimeBaseMode,
    input  wire logic                            immediateUpdate,
    input  wire logic                            currentResetMode,
    input  wire logic                            masterDutySelect,
    input  wire logic                            centerAligned,
    input  wire logic [`CPG_PRESCALE_WIDTH-1:0]  pwmClockPrescale,
    input  wire logic [WIDTH-1:0]                dutyCycleValue,
    input  wire logic [WIDTH-1:0]                masterDutyValue,
    input  wire logic [WIDTH-1:0]                phaseShiftValue,
    input  wire logic [WIDTH-1:0]                masterPeriodValue,
    input  wire logic [WIDTH-1:0]                deadTimeValue,
    input  wire logic [WIDTH-1:0]                alternateDeadTimeValue,
    input  wire logic                            highSideOverrideEnable,
    input  wire logic                            lowSideOverrideEnable,
    input  wire logic [1:0]                      overrideDataField,
    input  wire logic                            overrideSyncSelect,
    input  wire logic [`CPG_LIMIT_SEL_WIDTH-1:0] limitSourceSelect,
    input  wire logic [LIMIT_SOURCES-1:0]        limitComparator,
    output logic                                 highSideOutput,
    output logic                                 lowSideOutput,
    output logic [WIDTH-1:0]                     timeBaseCount,
    output logic                                 periodMark
);
    if (WIDTH < 2 || WIDTH > 32) begin : g_bad_width
        $error("WIDTH must lie between 2 and 32");
    end
    if (LIMIT_SOURCES != (1 << `CPG_LIMIT_SEL_WIDTH)) begin : g_bad_sources
        $error("LIMIT_SOURCES must match the select field");
    end

    logic                 tick;
    logic                 run;
    logic                 boundary;
    logic                 limitLevel;
    logic                 limitPrev;
    logic                 next_limitPrev;
    logic                 limitEvent;
    logic [WIDTH-1:0]     count;
    logic [WIDTH-1:0]     next_count;
    cpg_pkg::cpg_dir_e    dir;
    cpg_pkg::cpg_dir_e    next_dir;
    logic [WIDTH-1:0]     periodSel;
    logic [WIDTH-1:0]     dutySel;
    logic [WIDTH-1:0]     periodAct;
    logic [WIDTH-1:0]     next_periodAct;
    logic [WIDTH-1:0]     dutyAct;
    logic [WIDTH-1:0]     next_dutyAct;
    logic                 ovHigh;
    logic                 next_ovHigh;
    logic                 ovLow;
    logic                 next_ovLow;
    logic [1:0]           ovData;
    logic [1:0]           next_ovData;
    logic                 rawHigh;
    logic                 reqHigh;
    logic                 reqLow;
    logic                 next_periodMark;

    assign run = timeBaseEnable;

    cpg_prescaler u_prescaler (
        .prescale (pwmClockPrescale),
        .mclk     (mclk),
        .rst_b    (rst_b),
        .run      (run),
        .tick     (tick)
    );

    // Compare of count against duty, shared by both alignments
    function automatic logic below_duty(input logic [WIDTH-1:0] cnt, input logic [WIDTH-1:0] duty,
                                        input logic lead);
        logic [WIDTH:0] c;
        c = {1'b0, cnt} + (WIDTH+1)'(lead);
        return c < {1'b0, duty};
    endfunction : below_duty

    // Time base and limit detection
    always_comb begin
        periodSel      = independentTimeBaseMode ? phaseShiftValue : masterPeriodValue;
        dutySel        = masterDutySelect ? masterDutyValue : dutyCycleValue;
        limitLevel     = limitComparator[limitSourceSelect];
        next_limitPrev = limitLevel;
        // Edge detect so a long limit pulse restarts the cycle only once
        limitEvent     = run && currentResetMode && limitLevel && !limitPrev;
        next_count     = count;
        next_dir       = dir;
        boundary       = 1'b0;
        if (!run) begin
            next_count = '0;
            next_dir   = cpg_pkg::CPG_COUNT_UP;
        end else if (limitEvent) begin
            next_count = '0;
            next_dir   = cpg_pkg::CPG_COUNT_UP;
            boundary   = 1'b1;
        end else if (tick) begin
            unique case (dir)
                cpg_pkg::CPG_COUNT_UP: begin
                    if (count >= periodAct) begin
                        if (centerAligned) begin
                            next_dir   = cpg_pkg::CPG_COUNT_DOWN;
                            next_count = count - WIDTH'(1);
                        end else begin
                            next_count = '0;
                            boundary   = 1'b1;
                        end
                    end else begin
                        next_count = count + WIDTH'(1);
                    end
                end
                cpg_pkg::CPG_COUNT_DOWN: begin
                    if (count == '0) begin
                        next_dir   = cpg_pkg::CPG_COUNT_UP;
                        next_count = WIDTH'(1);
                        boundary   = 1'b1;
                    end else begin
                        next_count = count - WIDTH'(1);
                    end
                end
            endcase
        end
        next_periodMark = boundary;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            count      <= '0;
            dir        <= cpg_pkg::CPG_COUNT_UP;
            limitPrev  <= 1'b0;
            periodMark <= 1'b0;
        end else begin
            count      <= next_count;
            dir        <= next_dir;
            limitPrev  <= next_limitPrev;
            periodMark <= next_periodMark;
        end
    end

    assign timeBaseCount = count;

    // Duty and period buffers, plus override state
    always_comb begin
        next_dutyAct   = dutyAct;
        next_periodAct = periodAct;
        if (immediateUpdate || boundary || !run) begin
            next_dutyAct   = dutySel;
            next_periodAct = periodSel;
        end
        next_ovHigh = ovHigh;
        next_ovLow  = ovLow;
        next_ovData = ovData;
        // Period sync trades response time for whole-period output states
        if (!overrideSyncSelect || boundary || !run) begin
            next_ovHigh = highSideOverrideEnable;
            next_ovLow  = lowSideOverrideEnable;
            next_ovData = overrideDataField;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dutyAct   <= '0;
            periodAct <= '0;
            ovHigh    <= 1'b0;
            ovLow     <= 1'b0;
            ovData    <= 2'h0;
        end else begin
            dutyAct   <= next_dutyAct;
            periodAct <= next_periodAct;
            ovHigh    <= next_ovHigh;
            ovLow     <= next_ovLow;
            ovData    <= next_ovData;
        end
    end

    // Raw waveform; the end states have no edges so dead time never eats them
    always_comb begin
        if (dutyAct == '0) begin
            rawHigh = 1'b0;
        end else if (dutyAct >= periodAct) begin
            rawHigh = 1'b1;
        end else if (centerAligned) begin
            rawHigh = below_duty(count, dutyAct, 1'(`CPG_CENTER_LEAD));
        end else begin
            rawHigh = below_duty(count, dutyAct, 1'b0);
        end
        reqHigh = ovHigh ? ovData[`CPG_OVR_HIGH_BIT] : rawHigh;
        reqLow  = ovLow ? ovData[`CPG_OVR_LOW_BIT] : !rawHigh;
    end

    // Overrides feed the same dead-time stage, so release cannot glitch
    cpg_dead_time #(
        .WIDTH (WIDTH)
    ) u_dead_time (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .run     (run),
        .tick    (tick),
        .reqHigh (reqHigh),
        .reqLow  (reqLow),
        .dtHigh  (deadTimeValue),
        .dtLow   (alternateDeadTimeValue),
        .outHigh (highSideOutput),
        .outLow  (lowSideOutput)
    );

    chk_zero_duty: assert property (@(posedge mclk) disable iff (!rst_b)
        run && !ovHigh && !ovLow && dutyAct == '0 |-> !reqHigh && reqLow)
        else $error("zero duty must hold only the low side");

    chk_full_duty: assert property (@(posedge mclk) disable iff (!rst_b)
        run && !ovLow && dutyAct != '0 && dutyAct >= periodAct |-> !reqLow)
        else $error("full duty must hold off the low side");

    chk_full_steady: assert property (@(posedge mclk) disable iff (!rst_b)
        (run && !ovHigh && !ovLow && dutyAct != '0 && dutyAct >= periodAct &&
         deadTimeValue == '0 && alternateDeadTimeValue == '0) [*3] |-> highSideOutput)
        else $error("full duty did not settle on the high side");

    chk_override_data: assert property (@(posedge mclk) disable iff (!rst_b)
        ovHigh && ovLow && ovData == `CPG_OVR_ZERO_DUTY |-> !reqHigh && reqLow)
        else $error("override 01 must give the zero-duty state");

    chk_override_sync: assert property (@(posedge mclk) disable iff (!rst_b)
        run && overrideSyncSelect && !boundary |=> $stable(ovHigh) && $stable(ovData))
        else $error("synchronised override changed mid-period");

    chk_override_now: assert property (@(posedge mclk) disable iff (!rst_b)
        !overrideSyncSelect |=> ovLow == $past(lowSideOverrideEnable))
        else $error("unsynchronised override did not apply next clock");

    chk_buffered_duty: assert property (@(posedge mclk) disable iff (!rst_b)
        run && !immediateUpdate && !boundary |=> $stable(dutyAct))
        else $error("buffered duty changed away from a boundary");

    chk_immediate_duty: assert property (@(posedge mclk) disable iff (!rst_b)
        immediateUpdate |=> dutyAct == $past(dutySel))
        else $error("immediate duty write did not land");

    chk_limit_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        limitEvent |=> count == '0 && periodMark)
        else $error("limit event did not restart the cycle");

    chk_period_wrap: assert property (@(posedge mclk) disable iff (!rst_b)
        run && tick && !centerAligned && !limitEvent && count >= periodAct |=> count == '0)
        else $error("edge time base did not wrap at the period");
endmodule : cpg_generator

// ---- testbench/cpg_power_stage.sv ----
// Power stage model: gate-drive overlap and dead-time monitor, current-sense comparator bank
`timescale 1ns/1ps

module cpg_power_stage (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        highSide,
    input  wire logic        lowSide,
    input  wire logic [15:0] dtHigh,
    input  wire logic [15:0] dtLow,
    input  wire logic        fire,
    input  wire logic [4:0]  fireIndex,
    output logic [31:0]      limitComparator,
    output int               faults
);
    int   offRun;
    logic prevHigh;
    logic prevLow;
    int   pulseLeft;

    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            offRun          <= 0;
            prevHigh        <= 1'b0;
            prevLow         <= 1'b0;
            faults          <= 0;
            pulseLeft       <= 0;
            limitComparator <= 32'h0;
        end else begin
            prevHigh <= highSide;
            prevLow  <= lowSide;
            offRun   <= (highSide || lowSide) ? 0 : offRun + 1;
            // A gap shorter than dead time would short the bridge
            if (highSide && lowSide) begin
                faults <= faults + 1;
            end else if ((highSide && !prevHigh && offRun < dtHigh) ||
                         (lowSide && !prevLow && offRun < dtLow)) begin
                faults <= faults + 1;
            end
            // Sense comparator trips for two clocks, then falls back to its idle level
            if (fire) begin
                limitComparator <= 32'h1 << fireIndex;
                pulseLeft       <= 1;
            end else if (pulseLeft > 0) begin
                pulseLeft <= pulseLeft - 1;
            end else begin
                limitComparator <= 32'h0;
            end
        end
    end
endmodule : cpg_power_stage

// ---- testbench/testbench.sv ----
// Self-checking testbench for the complementary PWM generator
`timescale 1ns/1ps

module testbench;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        en = 1'b0, independent_time_base_mode = 1'b1, imm = 1'b1, crm = 1'b0, mds = 1'b0, ctr = 1'b0;
    logic [2:0]  pre = 3'h0;
    logic [15:0] duty = 16'h0, mduty = 16'h0, phase = 16'h9, mper = 16'hd, dt = 16'h2, adt = 16'h2;
    logic        ovH = 1'b0, ovL = 1'b0, override_sync_select = 1'b0, fire = 1'b0;
    logic [1:0]  ovData = 2'h0;
    logic [4:0]  sel = 5'h5, fireIdx = 5'h0;
    logic [31:0] cmp;
    logic        hiOut, loOut, periodMark;
    logic [15:0] count;
    int          faults, n_fail = 0, checks_done = 0, hi, lo, cyc;

    always #20 mclk = ~mclk;

    cpg_generator cpg_generator_inst (
        .mclk(mclk), .rst_b(rst_b), .timeBaseEnable(en), .independentTimeBaseMode(independent_time_base_mode),
        .immediateUpdate(imm), .currentResetMode(crm), .masterDutySelect(mds), .centerAligned(ctr),
        .pwmClockPrescale(pre), .dutyCycleValue(duty), .masterDutyValue(mduty),
        .phaseShiftValue(phase), .masterPeriodValue(mper), .deadTimeValue(dt),
        .alternateDeadTimeValue(adt), .highSideOverrideEnable(ovH), .lowSideOverrideEnable(ovL),
        .overrideDataField(ovData), .overrideSyncSelect(override_sync_select), .limitSourceSelect(sel),
        .limitComparator(cmp), .highSideOutput(hiOut), .lowSideOutput(loOut),
        .timeBaseCount(count), .periodMark(periodMark)
    );

    cpg_power_stage cpg_power_stage_inst (
        .mclk(mclk), .rst_b(rst_b), .highSide(hiOut), .lowSide(loOut), .dtHigh(dt), .dtLow(adt),
        .fire(fire), .fireIndex(fireIdx), .limitComparator(cmp), .faults(faults)
    );

    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick

    task automatic waitMark;
        for (int i = 0; i < 3000; i++) begin
            @(negedge mclk);
            if (periodMark === 1'b1) return;
        end
        n_fail++;
        end_sim();
    endtask : waitMark

    // Counts output-on cycles over one full period, mark to mark
    task automatic measure;
        waitMark();
        hi = 0;
        lo = 0;
        cyc = 0;
        for (int i = 0; i < 3000; i++) begin
            @(negedge mclk);
            hi += (hiOut === 1'b1);
            lo += (loOut === 1'b1);
            cyc++;
            if (periodMark === 1'b1) return;
        end
        n_fail++;
        end_sim();
    endtask : measure

    // First period may straddle a setting change, so it is discarded
    task automatic settle;
        measure();
        measure();
    endtask : settle

    task automatic trip(input logic [4:0] idx, input logic exp);
        logic seen;
        seen = 1'b0;
        fireIdx = idx;
        fire = 1'b1;
        tick(1);
        fire = 1'b0;
        repeat (6) begin
            tick(1);
            if (periodMark === 1'b1) seen = 1'b1;
        end
        check(seen, exp);
    endtask : trip

    initial begin
        tick(4);
        rst_b = 1'b1;
        tick(1);
        check({hiOut, loOut}, 2'h0);
        en = 1'b1;
        settle();
        check({hi, lo}, {32'h0, cyc});
        duty = 16'h9;
        settle();
        check({hi, lo}, {cyc, 32'h0});
        dt = 16'h0;
        adt = 16'h0;
        duty = 16'ha;
        settle();
        check({hi, lo}, {cyc, 32'h0});
        duty = 16'h0;
        settle();
        check({hi, lo}, {32'h0, cyc});
        ctr = 1'b1;
        dt = 16'h2;
        duty = 16'hb;
        settle();
        check({hi, lo}, {cyc, 32'h0});
        duty = 16'h0;
        settle();
        check({hi, lo}, {32'h0, cyc});
        ctr = 1'b0;
        adt = 16'h2;
        duty = 16'h7;
        independent_time_base_mode = 1'b0;
        settle();
        check(cyc, 32'he);
        check(hi != 0 && lo != 0, 1'b1);
        independent_time_base_mode = 1'b1;
        settle();
        check(cyc, 32'ha);
        duty = 16'h0;
        mduty = 16'h9;
        mds = 1'b1;
        settle();
        check({hi, lo}, {cyc, 32'h0});
        mds = 1'b0;
        settle();
        check(hi, 32'h0);
        phase = 16'h3;
        duty = 16'h2;
        for (int c = 0; c < 8; c++) begin
            pre = c[2:0];
            settle();
            check(cyc, 32'h4 << ((c > 6) ? 6 : c));
        end
        pre = 3'h0;
        phase = 16'h14;
        duty = 16'h5;
        dt = 16'h0;
        adt = 16'h0;
        settle();
        tick(10);
        duty = 16'h11;
        tick(4);
        check(hiOut, 1'b1);
        imm = 1'b0;
        duty = 16'h5;
        tick(2);
        check(hiOut, 1'b1);
        measure();
        check(hi != 0 && hi <= 5, 1'b1);
        imm = 1'b1;
        dt = 16'h2;
        adt = 16'h2;
        duty = 16'ha;
        ovH = 1'b1;
        ovL = 1'b1;
        ovData = 2'h1;
        tick(6);
        check({hiOut, loOut}, 2'h1);
        ovData = 2'h2;
        tick(6);
        check({hiOut, loOut}, 2'h2);
        override_sync_select = 1'b1;
        waitMark();
        ovData = 2'h1;
        tick(3);
        check({hiOut, loOut}, 2'h2);
        waitMark();
        tick(6);
        check({hiOut, loOut}, 2'h1);
        override_sync_select = 1'b0;
        ovL = 1'b0;
        settle();
        check({hi == 0, lo != 0}, 2'h3);
        ovH = 1'b0;
        ovL = 1'b1;
        ovData = 2'h0;
        settle();
        check({hi != 0, lo == 0}, 2'h3);
        ovL = 1'b0;
        settle();
        check(hi != 0 && lo != 0, 1'b1);
        phase = 16'hc8;
        duty = 16'h64;
        crm = 1'b1;
        waitMark();
        tick(30);
        trip(5'h5, 1'b1);
        tick(20);
        trip(5'h5, 1'b1);
        trip(5'h6, 1'b0);
        sel = 5'h1f;
        trip(5'h1f, 1'b1);
        crm = 1'b0;
        trip(5'h1f, 1'b0);
        en = 1'b0;
        tick(3);
        check({hiOut, loOut, count}, 18'h0);
        check(faults, 32'h0);
        end_sim();
    end
endmodule : testbench
